// ===== src/dcc_pkg.sv
// Shared constants, types and states of the disk command interface
package dcc_pkg;
    // Device codes of the handled transfer instructions
    localparam logic [11:0] IOT_CLEAR_ALL = 12'hde9;
    localparam logic [11:0] IOT_READ_WC = 12'hdea;
    localparam logic [11:0] IOT_LOAD_WC = 12'hdeb;
    localparam logic [11:0] IOT_LOAD_CA = 12'hded;
    localparam logic [11:0] IOT_READ_CA = 12'hdef;
    localparam logic [11:0] IOT_LOAD_CMD = 12'hdda;
    // Command register field positions
    localparam int CMD_IE_CHANGE = 0;
    localparam int CMD_DONE_IE = 1;
    localparam int CMD_ERR_IE = 2;
    localparam int CMD_SEEK_ONLY = 4;
    localparam int CMD_HDR_ACCESS = 5;
    localparam int CMD_EMA_LSB = 6;
    localparam int CMD_EMA_MSB = 8;
    localparam int CMD_DRV_LSB = 9;
    localparam int CMD_DRV_MSB = 10;
    // Reset values
    localparam logic [11:0] CMD_RESET = 12'h000;
    localparam logic [11:0] WC_RESET = 12'h000;
    localparam logic [11:0] CA_RESET = 12'h000;
    localparam logic [7:0] TRACK_ZERO = 8'h00;
    // Word limits of one sector transfer
    localparam logic [8:0] HDR_MAX_WORDS = 9'h102;
    localparam logic [8:0] DATA_MAX_WORDS = 9'h100;
    // Answer to the host accumulator
    typedef struct packed {
        logic clr;
        logic wr;
        logic [11:0] data;
    } dcc_acc_s;
    // Operation sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_SEEK_DROP,
        SEQ_SEEK_WAIT,
        SEQ_XFER,
        SEQ_END
    } dcc_seq_e;
endpackage : dcc_pkg

// ===== src/dcc_sync3.sv
// Three-stage pin synchroniser that accepts a level once stages two and three agree
module dcc_sync3 (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Synchronised reset
    input wire logic pin_i, // Asynchronous pin
    output logic level_o // Accepted level
);
    logic s1_reg, s2_reg, s3_reg, level_reg, level_next;

    // Accept only a level seen by two stages in a row
    always_comb
    begin
        level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
    end

    // Shift chain and accepted level
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;
endmodule : dcc_sync3

// ===== src/dcc_seq.sv
// Operation sequencer: seek, optional transfer, end of operation
module dcc_seq (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Synchronised reset
    input wire logic recal_i, // Clear-all recalibrate request
    input wire logic start_i, // Start a programmed operation
    input wire logic seek_only_i, // Seek without transfer
    input wire logic on_track_i, // Heads on track, synchronised
    input wire logic xfer_end_i, // Data transfer finished
    input wire logic error_i, // Error ends the operation
    output logic seek_req_o, // Seek request level
    output logic xfer_start_o, // Transfer start pulse
    output logic op_end_o, // Operation end pulse
    output logic busy_o // Operation in progress
);
    dcc_pkg::dcc_seq_e state_reg, state_next;
    logic xs_reg, xs_next, noxfer_reg, noxfer_next;
    logic seek_reg, seek_next, end_reg, end_next, busy_reg, busy_next;

    // Next state: new seek, wait drop and rise of on-track, then transfer, or end at once for seek-only and recalibrate
    always_comb
    begin
        state_next = state_reg;
        xs_next = 1'b0;
        noxfer_next = noxfer_reg;
        unique case (state_reg)
            dcc_pkg::SEQ_IDLE:
                if (recal_i || start_i)
                begin
                    state_next = dcc_pkg::SEQ_SEEK_DROP;
                    noxfer_next = recal_i || seek_only_i;
                end
            dcc_pkg::SEQ_SEEK_DROP:
                if (!on_track_i)
                    state_next = dcc_pkg::SEQ_SEEK_WAIT;
            dcc_pkg::SEQ_SEEK_WAIT:
                if (on_track_i)
                begin
                    state_next = noxfer_reg ? dcc_pkg::SEQ_END : dcc_pkg::SEQ_XFER;
                    xs_next = !noxfer_reg;
                end
            dcc_pkg::SEQ_XFER:
                if (xfer_end_i)
                    state_next = dcc_pkg::SEQ_END;
            dcc_pkg::SEQ_END:
                state_next = dcc_pkg::SEQ_IDLE;
            default:
                state_next = dcc_pkg::SEQ_IDLE;
        endcase
        if (error_i && state_reg != dcc_pkg::SEQ_IDLE && state_reg != dcc_pkg::SEQ_END)
        begin
            state_next = dcc_pkg::SEQ_END;
            xs_next = 1'b0;
        end
        if (recal_i && state_reg != dcc_pkg::SEQ_IDLE)
        begin
            state_next = dcc_pkg::SEQ_SEEK_DROP;
            noxfer_next = 1'b1;
            xs_next = 1'b0;
        end
        // Output levels taken from the coming state, so they leave a flip-flop
        seek_next = (state_next == dcc_pkg::SEQ_SEEK_DROP) ||
            (state_next == dcc_pkg::SEQ_SEEK_WAIT);
        end_next = (state_next == dcc_pkg::SEQ_END);
        busy_next = (state_next != dcc_pkg::SEQ_IDLE);
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= dcc_pkg::SEQ_IDLE;
            xs_reg <= 1'b0;
            noxfer_reg <= 1'b0;
            seek_reg <= 1'b0;
            end_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            xs_reg <= xs_next;
            noxfer_reg <= noxfer_next;
            seek_reg <= seek_next;
            end_reg <= end_next;
            busy_reg <= busy_next;
        end
    end

    assign seek_req_o = seek_reg;
    assign xfer_start_o = xs_reg;
    assign op_end_o = end_reg;
    assign busy_o = busy_reg;
endmodule : dcc_seq

// ===== src/dcc_cmd_if.sv
// Programmed-I/O command interface of the cartridge disk controller
// How it works
// R1 - Clear-all seeks track zero, clears registers and flags, keeps drive selection.
// R2 - After clear-all, done flag sets when heads reach track zero or when an error ends the seek.
// R3 - Read word count clears accumulator, then returns the word count.
// R4 - Load word count captures accumulator, then clears it.
// R5 - Load current address captures accumulator, then clears it.
// R6 - Read current address clears accumulator, then returns the current address.
// R7 - Load command copies accumulator into command register, then clears it.
// R8 - Interrupt enables change on command load only when bit 0 is one.
// R9 - With bit 0 set, bit 1 sets or resets the done interrupt enable.
// R10 - With bit 0 set, bit 2 sets or resets the error interrupt enable.
// R11 - Bit 4 set seeks track only; clear seeks and then transfers.
// R12 - Bit 5 set makes sector header words ordinary transfer words.
// R13 - Header-access read moves headers then data, at most 258, word count minimum.
// R14 - Header-access write uses the same word limits as header-access read.
// R15 - Program rewrites sector data whenever it changes header words.
// R16 - Command bits 6 and 7 are extended memory address bits 0 and 1.
// R17 - Bit 8 is extended address bit 2; bits 9-10 select drives 0-3.
// R18 - Done flag sets whenever any operation ends, normally or by error.
// R19 - Interrupt request while an enabled done or error flag is set.
module dcc_cmd_if (
    input wire logic clk_i, // System clock, 20 MHz
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic iot_strobe_i, // Instruction valid pulse
    input wire logic [11:0] iot_code_i, // Instruction code
    input wire logic [11:0] acc_i, // Host accumulator value
    input wire logic op_start_i, // Disk address loaded, start operation
    input wire logic op_write_i, // Started operation writes
    input wire logic [7:0] track_addr_i, // Track address register
    input wire logic on_track_i, // Drive heads on track, pin
    input wire logic xfer_end_i, // Datapath finished transfer
    input wire logic op_error_i, // Error detected, pulse
    output dcc_pkg::dcc_acc_s acc_o, // Accumulator answer
    output logic seek_req_o, // Seek request level
    output logic [7:0] seek_track_o, // Track to seek
    output logic [1:0] drive_sel_o, // Selected drive
    output logic xfer_start_o, // Transfer start pulse
    output logic xfer_write_o, // Transfer direction write
    output logic header_mode_o, // Header words are transfer words
    output logic [8:0] word_limit_o, // Word limit of the transfer
    output logic [2:0] ext_addr_o, // Extended memory address
    output logic [11:0] cur_addr_o, // Current address register
    output logic busy_o, // Operation in progress
    output logic done_flag_o, // Transfer-complete flag
    output logic error_flag_o, // Error flag
    output logic irq_o // Interrupt request
);
    logic rst_a_reg, rst_b_reg, rst_n;
    logic on_track;
    logic [11:0] cmd_reg, cmd_next, wc_reg, wc_next, ca_reg, ca_next;
    logic done_ie_reg, done_ie_next, err_ie_reg, err_ie_next;
    logic done_reg, done_next, err_reg, err_next, irq_reg, irq_next;
    logic write_reg, write_next, recal_reg, recal_next;
    logic [7:0] track_reg, track_next;
    logic [8:0] lim_reg, lim_next;
    dcc_pkg::dcc_acc_s acc_reg, acc_next;
    logic do_clear, seq_req, seq_xs, seq_end, seq_busy;

    // Word limit: the word count as minimum, capped at the sector maximum
    function automatic logic [8:0] clamp_words(input logic [11:0] wc, input logic [8:0] cap);
        clamp_words = (wc > {3'h0, cap}) ? cap : wc[8:0];
    endfunction : clamp_words

    // Reset release through two flip-flops
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_a_reg <= 1'b0;
            rst_b_reg <= 1'b0;
        end
        else
        begin
            rst_a_reg <= 1'b1;
            rst_b_reg <= rst_a_reg;
        end
    end
    assign rst_n = rst_b_reg;

    // Drive on-track pin synchroniser
    dcc_sync3 u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .pin_i(on_track_i),
        .level_o(on_track)
    );

    assign do_clear = iot_strobe_i && (iot_code_i == dcc_pkg::IOT_CLEAR_ALL);

    // Operation sequencer
    dcc_seq u_seq (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .recal_i(recal_reg),
        .start_i(op_start_i),
        .seek_only_i(cmd_reg[dcc_pkg::CMD_SEEK_ONLY]),
        .on_track_i(on_track),
        .xfer_end_i(xfer_end_i),
        .error_i(op_error_i),
        .seek_req_o(seq_req),
        .xfer_start_o(seq_xs),
        .op_end_o(seq_end),
        .busy_o(seq_busy)
    );

    // Instruction decode, register loads and accumulator answers
    always_comb
    begin
        cmd_next = cmd_reg;
        wc_next = wc_reg;
        ca_next = ca_reg;
        done_ie_next = done_ie_reg;
        err_ie_next = err_ie_reg;
        recal_next = do_clear;
        acc_next = '0;
        if (iot_strobe_i)
        begin
            unique case (iot_code_i)
                dcc_pkg::IOT_CLEAR_ALL:
                begin
                    cmd_next = dcc_pkg::CMD_RESET; // R1
                    cmd_next[dcc_pkg::CMD_DRV_MSB:dcc_pkg::CMD_DRV_LSB] =
                        cmd_reg[dcc_pkg::CMD_DRV_MSB:dcc_pkg::CMD_DRV_LSB]; // R1
                    wc_next = dcc_pkg::WC_RESET; // R1
                    ca_next = dcc_pkg::CA_RESET; // R1
                    done_ie_next = 1'b0; // R8
                    err_ie_next = 1'b0; // R8
                end
                dcc_pkg::IOT_READ_WC:
                begin
                    acc_next.clr = 1'b1; // R3
                    acc_next.wr = 1'b1;
                    acc_next.data = wc_reg;
                end
                dcc_pkg::IOT_LOAD_WC:
                begin
                    wc_next = acc_i; // R4
                    acc_next.clr = 1'b1;
                end
                dcc_pkg::IOT_LOAD_CA:
                begin
                    ca_next = acc_i; // R5
                    acc_next.clr = 1'b1;
                end
                dcc_pkg::IOT_READ_CA:
                begin
                    acc_next.clr = 1'b1; // R6
                    acc_next.wr = 1'b1;
                    acc_next.data = ca_reg;
                end
                dcc_pkg::IOT_LOAD_CMD:
                begin
                    cmd_next = acc_i; // R7
                    acc_next.clr = 1'b1;
                    if (acc_i[dcc_pkg::CMD_IE_CHANGE]) // R8
                    begin
                        done_ie_next = acc_i[dcc_pkg::CMD_DONE_IE]; // R9
                        err_ie_next = acc_i[dcc_pkg::CMD_ERR_IE]; // R10
                    end
                end
                default:
                    acc_next = '0;
            endcase
        end
    end

    // Flags, seek target, transfer setup and interrupt request
    always_comb
    begin
        done_next = done_reg;
        err_next = err_reg;
        write_next = write_reg;
        track_next = track_reg;
        lim_next = lim_reg;
        if (do_clear)
        begin
            done_next = 1'b0; // R1
            err_next = 1'b0;
            track_next = dcc_pkg::TRACK_ZERO; // R1
        end
        else if (op_start_i && !seq_busy)
        begin
            done_next = 1'b0;
            write_next = op_write_i;
            track_next = track_addr_i; // R11
            lim_next = cmd_reg[dcc_pkg::CMD_HDR_ACCESS] ?
                clamp_words(wc_reg, dcc_pkg::HDR_MAX_WORDS) :
                clamp_words(wc_reg, dcc_pkg::DATA_MAX_WORDS); // R13 R14
        end
        if (op_error_i && seq_busy)
            err_next = 1'b1;
        if (seq_end)
            done_next = 1'b1; // R2 R18
        irq_next = (done_next && done_ie_next) || (err_next && err_ie_next); // R19
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_reg <= dcc_pkg::CMD_RESET;
            wc_reg <= dcc_pkg::WC_RESET;
            ca_reg <= dcc_pkg::CA_RESET;
            done_ie_reg <= 1'b0;
            err_ie_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            irq_reg <= 1'b0;
            write_reg <= 1'b0;
            recal_reg <= 1'b0;
            track_reg <= dcc_pkg::TRACK_ZERO;
            lim_reg <= 9'h000;
            acc_reg <= '0;
        end
        else
        begin
            cmd_reg <= cmd_next;
            wc_reg <= wc_next;
            ca_reg <= ca_next;
            done_ie_reg <= done_ie_next;
            err_ie_reg <= err_ie_next;
            done_reg <= done_next;
            err_reg <= err_next;
            irq_reg <= irq_next;
            write_reg <= write_next;
            recal_reg <= recal_next;
            track_reg <= track_next;
            lim_reg <= lim_next;
            acc_reg <= acc_next;
        end
    end

    // Outputs
    assign acc_o = acc_reg;
    assign seek_req_o = seq_req;
    assign seek_track_o = track_reg;
    assign drive_sel_o = cmd_reg[dcc_pkg::CMD_DRV_MSB:dcc_pkg::CMD_DRV_LSB]; // R17
    assign xfer_start_o = seq_xs; // R11
    assign xfer_write_o = write_reg;
    assign header_mode_o = cmd_reg[dcc_pkg::CMD_HDR_ACCESS]; // R12
    assign word_limit_o = lim_reg;
    assign ext_addr_o = cmd_reg[dcc_pkg::CMD_EMA_MSB:dcc_pkg::CMD_EMA_LSB]; // R16 R17
    assign cur_addr_o = ca_reg;
    assign busy_o = seq_busy;
    assign done_flag_o = done_reg;
    assign error_flag_o = err_reg;
    assign irq_o = irq_reg;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_clear_cmd;
        iot_strobe_i && iot_code_i == dcc_pkg::IOT_CLEAR_ALL;
    endsequence

    sequence s_load(logic [11:0] code);
        iot_strobe_i && iot_code_i == code;
    endsequence

    chk_clear_keeps_drive: assert property (s_clear_cmd |=> // R1
        cmd_reg == {1'b0, $past(drive_sel_o), 9'h000} && wc_reg == 12'h000 && !done_reg)
        else $error("clear-all did not clear registers or lost drive selection");
    chk_clear_seeks_zero: assert property (s_clear_cmd |=> ##1 seek_req_o // R1
        && seek_track_o == 8'h00)
        else $error("clear-all did not seek track zero");
    chk_done_after_track: assert property ($rose(done_reg) && !err_reg |-> // R2
        $past(seq_end) && $past(on_track, 2))
        else $error("done flag rose without heads on track");
    chk_read_wc_answer: assert property (s_load(dcc_pkg::IOT_READ_WC) |=> // R3
        acc_o.clr && acc_o.wr && acc_o.data == $past(wc_reg))
        else $error("word count read answer wrong");
    chk_load_wc_value: assert property (s_load(dcc_pkg::IOT_LOAD_WC) |=> // R4
        wc_reg == $past(acc_i) && acc_o.clr && !acc_o.wr)
        else $error("word count load wrong");
    chk_load_ca_value: assert property (s_load(dcc_pkg::IOT_LOAD_CA) |=> // R5
        cur_addr_o == $past(acc_i) && acc_o.clr && !acc_o.wr)
        else $error("current address load wrong");
    chk_read_ca_answer: assert property (s_load(dcc_pkg::IOT_READ_CA) |=> // R6
        acc_o.clr && acc_o.wr && acc_o.data == $past(ca_reg))
        else $error("current address read answer wrong");
    chk_load_cmd_value: assert property (s_load(dcc_pkg::IOT_LOAD_CMD) |=> // R7
        cmd_reg == $past(acc_i) && acc_o.clr)
        else $error("command load wrong");
    chk_enables_locked: assert property (s_load(dcc_pkg::IOT_LOAD_CMD) // R8
        && !acc_i[0] |=> $stable(done_ie_reg) && $stable(err_ie_reg))
        else $error("interrupt enables changed with bit 0 clear");
    chk_done_enable_set: assert property (s_load(dcc_pkg::IOT_LOAD_CMD) // R9
        && acc_i[0] |=> done_ie_reg == $past(acc_i[1]))
        else $error("done interrupt enable not loaded");
    chk_err_enable_set: assert property (s_load(dcc_pkg::IOT_LOAD_CMD) // R10
        && acc_i[0] |=> err_ie_reg == $past(acc_i[2]))
        else $error("error interrupt enable not loaded");
    chk_seek_only_noxfer: assert property (busy_o && cmd_reg[4] && !$past(recal_reg) // R11
        && $stable(cmd_reg) && $past(seq_busy) |-> !xfer_start_o || !$past(cmd_reg[4]))
        else $error("transfer started in seek-only mode");
    chk_hdr_limit_cap: assert property (word_limit_o <= 9'h102) // R13 R14
        else $error("word limit above header-access maximum");
    chk_ext_addr_map: assert property (s_load(dcc_pkg::IOT_LOAD_CMD) |=> // R16 R17
        ext_addr_o == $past(acc_i[8:6]) && drive_sel_o == $past(acc_i[10:9])
        && header_mode_o == $past(acc_i[5]))
        else $error("command field mapping wrong");
    chk_end_sets_done: assert property (seq_end |=> done_reg) // R18
        else $error("operation end did not set done flag");
    chk_irq_follows: assert property (##1 irq_o == // R19
        ((done_reg && done_ie_reg) || (err_reg && err_ie_reg)))
        else $error("interrupt request does not follow flags and enables");
endmodule : dcc_cmd_if

// ===== verif/dcc_drive_model.sv
// Seek responder that stands in for the disk drive heads
module dcc_drive_model #(
    parameter int SETTLE = 6 // Cycles the heads spend moving
) (
    input wire logic clk_i, // System clock
    input wire logic seek_req_i, // Seek request from the controller
    output logic on_track_o // Heads on track
);
    timeunit 1ns;
    timeprecision 1ps;
    logic armed_reg = 1'b0;
    int wait_cnt = 0;
    initial on_track_o = 1'b1;
    // Drop on-track at each new seek, raise it only after the settle time
    always @(posedge clk_i)
    begin
        if (!seek_req_i)
        begin
            armed_reg <= 1'b0;
        end
        else if (!armed_reg)
        begin
            armed_reg <= 1'b1;
            on_track_o <= 1'b0;
            wait_cnt <= SETTLE;
        end
        else if (wait_cnt != 0)
        begin
            wait_cnt <= wait_cnt - 1;
        end
        else
        begin
            on_track_o <= 1'b1;
        end
    end
endmodule : dcc_drive_model

// ===== verif/dcc_cmd_if_tb_top.sv
// Self-checking bench of the disk command interface
module dcc_cmd_if_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] code; logic [11:0] acc; logic [13:0] exp;} dcc_row_s;
    logic clk_i = 1'b0, reset_n_i = 1'b0, iot_strobe_i = 1'b0, op_start_i = 1'b0;
    logic op_write_i = 1'b0, xfer_end_i = 1'b0, op_error_i = 1'b0, on_track_i;
    logic [11:0] iot_code_i = 12'h000, acc_i = 12'h000, cur_addr_o;
    logic [7:0] track_addr_i = 8'h00, seek_track_o;
    dcc_pkg::dcc_acc_s acc_o;
    logic seek_req_o, xfer_start_o, xfer_write_o, header_mode_o, busy_o;
    logic done_flag_o, error_flag_o, irq_o;
    logic [1:0] drive_sel_o;
    logic [8:0] word_limit_o;
    logic [2:0] ext_addr_o;
    logic xfer_seen;
    int fails = 0, check_count = 0;
    dcc_row_s rows[7] = '{
        '{dcc_pkg::IOT_LOAD_WC, 12'h0a5, 14'h2000}, '{dcc_pkg::IOT_READ_WC, 12'h7ff, 14'h30a5},
        '{dcc_pkg::IOT_LOAD_CA, 12'h123, 14'h2000}, '{dcc_pkg::IOT_READ_CA, 12'h000, 14'h3123},
        '{dcc_pkg::IOT_LOAD_CMD, 12'h000, 14'h2000}, '{12'hdee, 12'h555, 14'h0000},
        '{dcc_pkg::IOT_READ_WC, 12'h000, 14'h30a5}};

    dcc_cmd_if uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .iot_strobe_i(iot_strobe_i),
        .iot_code_i(iot_code_i), .acc_i(acc_i), .op_start_i(op_start_i),
        .op_write_i(op_write_i), .track_addr_i(track_addr_i), .on_track_i(on_track_i),
        .xfer_end_i(xfer_end_i), .op_error_i(op_error_i), .acc_o(acc_o),
        .seek_req_o(seek_req_o), .seek_track_o(seek_track_o), .drive_sel_o(drive_sel_o),
        .xfer_start_o(xfer_start_o), .xfer_write_o(xfer_write_o),
        .header_mode_o(header_mode_o), .word_limit_o(word_limit_o), .ext_addr_o(ext_addr_o),
        .cur_addr_o(cur_addr_o), .busy_o(busy_o), .done_flag_o(done_flag_o),
        .error_flag_o(error_flag_o), .irq_o(irq_o));
    dcc_drive_model #(.SETTLE(6)) drive (.clk_i(clk_i), .seek_req_i(seek_req_o),
        .on_track_o(on_track_i));

    // Free-running 20 MHz clock
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    // Compare and count
    task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Command word from its fields
    function automatic logic [11:0] cmd_word(input logic ie, dn, er, sk, hd,
        input logic [2:0] ext, input logic [1:0] drv);
        return {1'b0, drv, ext, hd, sk, 1'b0, er, dn, ie};
    endfunction : cmd_word

    // One transfer instruction; returns where the one-cycle answer stands
    task automatic io_transfer_instruction(input logic [11:0] code, input logic [11:0] acc);
        @(negedge clk_i);
        iot_strobe_i = 1'b1;
        iot_code_i = code;
        acc_i = acc;
        @(negedge clk_i);
        iot_strobe_i = 1'b0;
    endtask : io_transfer_instruction

    // Pulse one input for a single cycle
    task automatic pulse(ref logic sig);
        @(negedge clk_i);
        sig = 1'b1;
        @(negedge clk_i);
        sig = 1'b0;
    endtask : pulse

    // Wait for the transfer start or the done flag, noting any transfer start
    task automatic wait_for(input bit want_xfer);
        int n;
        n = 0;
        while ((want_xfer ? xfer_start_o : done_flag_o) !== 1'b1 && n < 400)
        begin
            @(negedge clk_i);
            xfer_seen = xfer_seen | (xfer_start_o === 1'b1);
            n++;
        end
        chk(want_xfer ? "xfer start" : "done flag", 14'(n < 400), 14'h1);
    endtask : wait_for

    // Verdict and end of run
    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // Watchdog against a hung handshake
    initial
    begin
        #(8000 * 50);
        fails++;
        $display("[ERR] watchdog expected end of tests seen timeout");
        wrap_up();
    end

    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("reset state", 14'({acc_o == '0, busy_o, done_flag_o, error_flag_o, irq_o}), 14'h10);
        $display("reset test done");
        foreach (rows[i])
        begin
            io_transfer_instruction(rows[i].code, rows[i].acc);
            chk("accumulator answer", 14'(acc_o), rows[i].exp);
        end
        chk("current address", 14'(cur_addr_o), 14'h123);
        $display("register test done");
        io_transfer_instruction(dcc_pkg::IOT_LOAD_CMD, cmd_word(1, 1, 0, 1, 1, 3'h5, 2'h2));
        chk("fields", 14'({drive_sel_o, ext_addr_o, header_mode_o}), 14'h2b);
        io_transfer_instruction(dcc_pkg::IOT_LOAD_WC, 12'h101);
        track_addr_i = 8'h2a;
        xfer_seen = 1'b0;
        pulse(op_start_i);
        @(negedge clk_i);
        chk("seek track", 14'(seek_track_o), 14'h2a);
        chk("header limit", 14'(word_limit_o), 14'h101);
        wait_for(0);
        @(negedge clk_i);
        chk("seek only no xfer", 14'(xfer_seen), 14'h0);
        chk("done irq", 14'({irq_o, error_flag_o}), 14'h2);
        io_transfer_instruction(dcc_pkg::IOT_LOAD_CMD, cmd_word(0, 0, 0, 1, 0, 3'h0, 2'h2));
        @(negedge clk_i);
        chk("enables kept", 14'(irq_o), 14'h1);
        io_transfer_instruction(dcc_pkg::IOT_LOAD_CMD, cmd_word(1, 0, 0, 1, 0, 3'h0, 2'h2));
        @(negedge clk_i);
        chk("done enable off", 14'(irq_o), 14'h0);
        $display("seek test done");
        io_transfer_instruction(dcc_pkg::IOT_LOAD_CMD, cmd_word(1, 1, 0, 0, 1, 3'h7, 2'h2));
        io_transfer_instruction(dcc_pkg::IOT_CLEAR_ALL, 12'h000);
        chk("clear answer", 14'(acc_o), 14'h0);
        chk("cleared regs", 14'({cur_addr_o, ext_addr_o == 3'h0}), 14'h1);
        chk("drive kept", 14'({drive_sel_o, header_mode_o}), 14'h4);
        @(negedge clk_i);
        chk("recalibrate", 14'({seek_req_o, busy_o, done_flag_o, seek_track_o}), 14'h600);
        wait_for(0);
        chk("heads on track", 14'(on_track_i), 14'h1);
        @(negedge clk_i);
        chk("enables cleared", 14'(irq_o), 14'h0);
        io_transfer_instruction(dcc_pkg::IOT_READ_WC, 12'h000);
        chk("count cleared", 14'(acc_o), 14'h3000);
        $display("clear test done");
        io_transfer_instruction(dcc_pkg::IOT_LOAD_CMD, cmd_word(1, 0, 1, 0, 1, 3'h0, 2'h1));
        io_transfer_instruction(dcc_pkg::IOT_LOAD_WC, 12'h200);
        op_write_i = 1'b1;
        pulse(op_start_i);
        wait_for(1);
        chk("header write", 14'({xfer_write_o, word_limit_o}), 14'h302);
        pulse(op_error_i);
        wait_for(0);
        @(negedge clk_i);
        chk("error end", 14'({error_flag_o, irq_o}), 14'h3);
        io_transfer_instruction(dcc_pkg::IOT_CLEAR_ALL, 12'h000);
        chk("error cleared", 14'(error_flag_o), 14'h0);
        wait_for(0);
        $display("error test done");
        io_transfer_instruction(dcc_pkg::IOT_LOAD_CMD, cmd_word(0, 0, 0, 0, 0, 3'h0, 2'h3));
        io_transfer_instruction(dcc_pkg::IOT_LOAD_WC, 12'h0ff);
        op_write_i = 1'b0;
        pulse(op_start_i);
        wait_for(1);
        chk("plain read", 14'({xfer_write_o, word_limit_o}), 14'h0ff);
        pulse(xfer_end_i);
        wait_for(0);
        chk("normal end", 14'({busy_o, error_flag_o}), 14'h0);
        $display("transfer test done");
        wrap_up();
    end
endmodule : dcc_cmd_if_tb_top
